// [common/uart_reg_pkg.sv]
// constants for the serial channel register block
package uart_reg_pkg;

  // =====================================================
  // register offsets, channel 0, stride per channel
  localparam logic [7:0] OFF_STATUS_A   = 8'hc0;
  localparam logic [7:0] OFF_STATUS_B   = 8'hc1;
  localparam logic [7:0] OFF_FRAME_CTRL = 8'hc2;
  localparam logic [7:0] OFF_DATA_PORT  = 8'hc6;
  localparam logic [7:0] CHANNEL_STRIDE = 8'h08;

  // =====================================================
  // reset values
  localparam logic [7:0] RST_STATUS_A   = 8'h20;
  localparam logic [7:0] RST_STATUS_B   = 8'h00;
  localparam logic [7:0] RST_FRAME_CTRL = 8'h06;
  localparam logic [7:0] RST_DATA_PORT  = 8'h00;

  // =====================================================
  // status a bit positions
  localparam int A_RX_DONE  = 7;
  localparam int A_TX_DONE  = 6;
  localparam int A_EMPTY    = 5;
  localparam int A_FRAME    = 4;
  localparam int A_OVERRUN  = 3;
  localparam int A_PARITY   = 2;
  localparam int A_DOUBLE   = 1;
  localparam int A_MPFILTER = 0;

  // =====================================================
  // status b bit positions
  localparam int B_RX_IE    = 7;
  localparam int B_TX_IE    = 6;
  localparam int B_EMPTY_IE = 5;
  localparam int B_RX_EN    = 4;
  localparam int B_TX_EN    = 3;
  localparam int B_SIZE_HI  = 2;
  localparam int B_RX_BIT8  = 1;
  localparam int B_TX_BIT8  = 0;

  // =====================================================
  // frame control fields
  localparam int C_MODE_LSB   = 6;
  localparam int C_PARITY_LSB = 4;
  localparam int C_STOP       = 3;
  localparam int C_SIZE_LSB   = 1;

  localparam logic [1:0] MODE_ASYNC  = 2'b00;
  localparam logic [1:0] MODE_SYNC   = 2'b01;
  localparam logic [1:0] MODE_SPI    = 2'b11;
  localparam logic [1:0] PAR_OFF     = 2'b00;
  localparam logic [1:0] PAR_EVEN    = 2'b10;
  localparam logic [1:0] PAR_ODD     = 2'b11;
  localparam logic [2:0] SIZE_5      = 3'b000;
  localparam logic [2:0] SIZE_6      = 3'b001;
  localparam logic [2:0] SIZE_7      = 3'b010;
  localparam logic [2:0] SIZE_8      = 3'b011;
  localparam logic [2:0] SIZE_9      = 3'b111;

  // =====================================================
  // oversampling per bit, receive fifo depth
  localparam logic [4:0] OVERSAMPLE_NORMAL = 5'h10;
  localparam logic [4:0] OVERSAMPLE_DOUBLE = 5'h08;
  localparam int         RX_FIFO_DEPTH     = 2;

endpackage

// [logic/uart_register_interface.sv]
// register interface and serial engine of one serial channel
//
// Overview of operation
// - one data-port address: writes fill transmit buffer, reads pop receive fifo head.
// - short characters: transmitter ignores upper bits, receiver returns them zero.
// - data-port write while buffer-empty flag clear is dropped, buffer unchanged.
// - enabled transmitter loads buffer into idle shifter, then shifts it out.
// - receive buffer is a two-entry fifo advanced by data-port reads.
// - status bit 7 high while fifo holds unread data, cleared by flush.
// - status bit 6 sets after frame out with buffer empty; cleared by ack or write-one.
// - status bit 5 high when transmit buffer free, high after reset.
// - status bit 4 is stop-bit error of fifo head character.
// - status bit 3 sets on start bit with fifo full and holding slot occupied.
// - status bit 2 is parity error of fifo head when checking enabled.
// - speed double selects divider 8 instead of 16 in asynchronous mode.
// - multiprocessor filter drops received frames without address mark.
// - each interrupt requested only when enable, global enable and flag set.
// - receiver enable owns receive pin; disable flushes fifo and error flags.
// - transmitter owns pin; disable waits until shifter and buffer empty.
// - size high bit joins two frame-control size bits into three-bit size.
// - received ninth bit readable in status b bit 1, read before data.
// - ninth transmit bit written in status b bit 0 before data.
// - mode field: 00 async; 01, 10 and 11 also run async frames, with speed double ignored.
// - parity field: 00 off, 10 even, 11 odd; mismatch flags error.
// - size codes 000..011 give five to eight bits, 111 nine.
// - stop select gives one or two transmitted stop bits; receiver ignores.
`timescale 1ns/1ps
module uart_register_interface
  import uart_reg_pkg::*;
#(
  parameter logic [7:0]  CHANNEL  = 8'h00,
  parameter logic [15:0] PRESCALE = 16'h000b
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       global_irq_enable,
  input  wire logic       tx_done_irq_ack,
  input  wire logic       receive_pin,
  output logic            transmit_pin,
  output logic            transmit_pin_owned,
  output logic            receive_pin_owned,
  output logic            irq_rx_done,
  output logic            irq_tx_done,
  output logic            irq_empty
);

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
    TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
  } tx_state_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
    RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
  } rx_state_e;

  // =====================================================
  // registers
  logic [7:0]  ctrl_b_q;
  logic [7:0]  frame_q;
  logic        speed_double_q;
  logic        multiproc_filter_q;
  logic        txc_q;
  logic        dor_q;
  logic [8:0]  txb_q;
  logic        txb_valid_q;
  logic        tx_own_q;
  logic [11:0] fifo_q [RX_FIFO_DEPTH];
  logic        rd_ptr_q;
  logic [1:0]  rx_cnt_q;
  logic [11:0] wait_q;
  logic        wait_valid_q;
  logic [15:0] pre_q;
  logic        tick_q;
  logic [1:0]  rx_sync_q;
  logic [7:0]  rdata_q;
  logic        tx_pin_q;
  logic        irq_rx_q;
  logic        irq_tx_q;
  logic        irq_empty_q;
  tx_state_e   tx_st_q;
  rx_state_e   rx_st_q;
  logic [4:0]  tx_os_q;
  logic [4:0]  rx_os_q;
  logic [3:0]  tx_idx_q;
  logic [3:0]  rx_idx_q;
  logic [8:0]  tx_sh_q;
  logic [8:0]  rx_sh_q;
  logic        rx_par_q;
  logic        tx_stop2_q;

  // =====================================================
  // address decode
  wire [7:0] base_w     = 8'(CHANNEL * CHANNEL_STRIDE);
  wire       sel_a_w    = (addr == 8'(OFF_STATUS_A + base_w));
  wire       sel_b_w    = (addr == 8'(OFF_STATUS_B + base_w));
  wire       sel_c_w    = (addr == 8'(OFF_FRAME_CTRL + base_w));
  wire       sel_d_w    = (addr == 8'(OFF_DATA_PORT + base_w));
  wire       wr_a_w     = wr && sel_a_w;
  wire       wr_b_w     = wr && sel_b_w;
  wire       wr_c_w     = wr && sel_c_w;
  wire       wr_d_w     = wr && sel_d_w;
  wire       pop_w      = rd && sel_d_w && (rx_cnt_q != 2'h0);

  // =====================================================
  // frame format
  wire [2:0] size_w    = {ctrl_b_q[B_SIZE_HI], frame_q[C_SIZE_LSB+1:C_SIZE_LSB]};
  wire [1:0] par_w     = frame_q[C_PARITY_LSB+1:C_PARITY_LSB];
  wire [1:0] mode_w    = frame_q[C_MODE_LSB+1:C_MODE_LSB];
  wire       par_en_w  = par_w[1];
  wire       is_nine_w = (size_w == SIZE_9);
  wire       receiver_enable_w    = ctrl_b_q[B_RX_EN];
  wire [3:0] nbits_w   = (size_w == SIZE_5) ? 4'h5 :
                         (size_w == SIZE_6) ? 4'h6 :
                         (size_w == SIZE_7) ? 4'h7 :
                         is_nine_w ? 4'h9 : 4'h8;
  wire [8:0] mask_w    = 9'((10'h001 << nbits_w) - 10'h001);
  wire [4:0] os_w      = (speed_double_q && mode_w == MODE_ASYNC) ?
                         OVERSAMPLE_DOUBLE : OVERSAMPLE_NORMAL;

  // =====================================================
  // status views
  wire [11:0] head_w   = fifo_q[rd_ptr_q];
  wire        rxc_w    = (rx_cnt_q != 2'h0);
  wire        buffer_empty_flag_w   = !txb_valid_q;
  wire [7:0]  stat_a_w = {rxc_w, txc_q, buffer_empty_flag_w, head_w[11] & rxc_w, dor_q,
                          head_w[10] & rxc_w, speed_double_q, multiproc_filter_q};
  wire [7:0]  stat_b_w = {ctrl_b_q[7:2], head_w[8] & rxc_w, ctrl_b_q[B_TX_BIT8]};
  wire [7:0]  rd_mux_w = sel_a_w ? stat_a_w :
                         sel_b_w ? stat_b_w :
                         sel_c_w ? frame_q :
                         sel_d_w ? head_w[7:0] : 8'h00;

  // =====================================================
  // register writes and read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_b_q           <= RST_STATUS_B;
      frame_q            <= RST_FRAME_CTRL;
      speed_double_q     <= RST_STATUS_A[A_DOUBLE];
      multiproc_filter_q <= RST_STATUS_A[A_MPFILTER];
      rdata_q            <= RST_DATA_PORT;
    end else begin
      if (wr_a_w) begin
        speed_double_q     <= wdata[A_DOUBLE];
        multiproc_filter_q <= wdata[A_MPFILTER];
      end
      if (wr_b_w) begin
        ctrl_b_q <= {wdata[7:2], 1'b0, wdata[B_TX_BIT8]};
      end
      if (wr_c_w) begin
        frame_q <= wdata;
      end
      rdata_q <= rd ? rd_mux_w : 8'h00;
    end
  end

  // transmit complete: set wins over clear
  wire tx_frame_end_w = (tx_st_q == TX_STOP) && tick_q && (tx_os_q == os_w - 5'h01) &&
                        !(frame_q[C_STOP] && !tx_stop2_q);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txc_q <= RST_STATUS_A[A_TX_DONE];
    end else if (tx_frame_end_w && !txb_valid_q) begin
      txc_q <= 1'b1;
    end else if (tx_done_irq_ack || (wr_a_w && wdata[A_TX_DONE])) begin
      txc_q <= 1'b0;
    end
  end

  // =====================================================
  // transmit buffer and pin ownership
  wire tx_load_w = (tx_st_q == TX_IDLE) && tx_own_q && txb_valid_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txb_q       <= 9'h000;
      txb_valid_q <= 1'b0;
      tx_own_q    <= 1'b0;
    end else begin
      if (wr_d_w && !txb_valid_q) begin
        txb_q       <= {ctrl_b_q[B_TX_BIT8], wdata};
        txb_valid_q <= 1'b1;
      end else if (tx_load_w) begin
        txb_valid_q <= 1'b0;
      end
      tx_own_q <= ctrl_b_q[B_TX_EN] ||
                  (tx_own_q && (txb_valid_q || tx_st_q != TX_IDLE));
    end
  end

  // =====================================================
  // sample tick prescaler
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == PRESCALE - 16'h0001);
      pre_q  <= (pre_q == PRESCALE - 16'h0001) ? 16'h0000 : pre_q + 16'h0001;
    end
  end

  // =====================================================
  // transmitter
  wire tx_bit_end_w = tick_q && (tx_os_q == os_w - 5'h01);
  wire tx_par_w     = ^(tx_sh_q & mask_w) ^ par_w[0];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_q    <= TX_IDLE;
      tx_os_q    <= 5'h00;
      tx_idx_q   <= 4'h0;
      tx_sh_q    <= 9'h000;
      tx_stop2_q <= 1'b0;
    end else begin
      if (tick_q) begin
        tx_os_q <= tx_bit_end_w ? 5'h00 : tx_os_q + 5'h01;
      end
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_load_w) begin
            tx_sh_q  <= txb_q;
            tx_st_q  <= TX_START;
            tx_os_q  <= 5'h00;
            tx_idx_q <= 4'h0;
          end
        end
        TX_START: begin
          if (tx_bit_end_w) begin
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end_w) begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (tx_idx_q == nbits_w - 4'h1) begin
              tx_st_q    <= par_en_w ? TX_PAR : TX_STOP;
              tx_stop2_q <= 1'b0;
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end_w) begin
            tx_st_q    <= TX_STOP;
            tx_stop2_q <= 1'b0;
          end
        end
        TX_STOP: begin
          if (tx_frame_end_w) begin
            tx_st_q <= TX_IDLE;
          end else if (tx_bit_end_w) begin
            tx_stop2_q <= 1'b1;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  wire tx_bit_w = (tx_st_q == TX_START) ? 1'b0 :
                  (tx_st_q == TX_DATA)  ? tx_sh_q[tx_idx_q] :
                  (tx_st_q == TX_PAR)   ? tx_par_w : 1'b1;

  // =====================================================
  // receiver
  wire rx_line_w    = rx_sync_q[1];
  wire rx_mid_w     = tick_q && (rx_os_q == os_w - 5'h01);
  wire rx_half_w    = tick_q && (rx_os_q == (os_w >> 1) - 5'h01);
  wire rx_start_w   = (rx_st_q == RX_IDLE) && receiver_enable_w && !rx_line_w;
  wire rx_done_w    = (rx_st_q == RX_STOP) && rx_mid_w;
  wire rx_addr_w    = is_nine_w ? rx_sh_q[8] : rx_line_w;
  wire rx_perr_w    = par_en_w && (rx_par_q != (^(rx_sh_q & mask_w) ^ par_w[0]));
  wire rx_keep_w    = rx_done_w && !wait_valid_q &&
                      !(multiproc_filter_q && !rx_addr_w);
  wire move_w       = wait_valid_q && (rx_cnt_q != 2'h2 || pop_w);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_sync_q <= 2'b11;
    end else begin
      rx_sync_q <= {rx_sync_q[0], receive_pin};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !receiver_enable_w) begin
      rx_st_q  <= RX_IDLE;
      rx_os_q  <= 5'h00;
      rx_idx_q <= 4'h0;
      rx_sh_q  <= 9'h000;
      rx_par_q <= 1'b0;
    end else begin
      if (tick_q) begin
        rx_os_q <= (rx_mid_w || rx_half_w && rx_st_q == RX_START) ? 5'h00 : rx_os_q + 5'h01;
      end
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_start_w) begin
            rx_st_q  <= RX_START;
            rx_os_q  <= 5'h00;
            rx_idx_q <= 4'h0;
            rx_sh_q  <= 9'h000;
          end
        end
        RX_START: begin
          if (rx_half_w) begin
            rx_st_q <= rx_line_w ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_mid_w) begin
            rx_sh_q[rx_idx_q] <= rx_line_w;
            rx_idx_q          <= rx_idx_q + 4'h1;
            if (rx_idx_q == nbits_w - 4'h1) begin
              rx_st_q <= par_en_w ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_mid_w) begin
            rx_par_q <= rx_line_w;
            rx_st_q  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid_w) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // =====================================================
  // receive fifo, holding slot and overrun
  always_ff @(posedge clk_sys) begin
    if (rst || !receiver_enable_w) begin
      rd_ptr_q     <= 1'b0;
      rx_cnt_q     <= 2'h0;
      wait_valid_q <= 1'b0;
      wait_q       <= 12'h000;
      dor_q        <= 1'b0;
    end else begin
      if (rx_start_w && rx_cnt_q == 2'h2 && wait_valid_q) begin
        dor_q <= 1'b1;
      end else if (pop_w) begin
        dor_q <= 1'b0;
      end
      if (rx_keep_w) begin
        wait_q       <= {!rx_line_w, rx_perr_w, 1'b0, rx_sh_q & mask_w};
        wait_valid_q <= 1'b1;
      end else if (move_w) begin
        wait_valid_q <= 1'b0;
      end
      if (pop_w) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      rx_cnt_q <= 2'(rx_cnt_q + {1'b0, move_w} - {1'b0, pop_w});
    end
  end

  // entries written in place, one slot per index
  for (genvar i = 0; i < RX_FIFO_DEPTH; i++) begin : g_fifo
    // slot after the last stored entry, taken before this cycle's pop
    wire [1:0] wr_slot_w = 2'(rd_ptr_q + rx_cnt_q);
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        fifo_q[i] <= 12'h000;
      end else if (move_w && wr_slot_w[0] == 1'(i)) begin
        fifo_q[i] <= wait_q;
      end
    end
  end

  // =====================================================
  // outputs and interrupt requests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_pin_q    <= 1'b1;
      irq_rx_q    <= 1'b0;
      irq_tx_q    <= 1'b0;
      irq_empty_q <= 1'b0;
    end else begin
      tx_pin_q    <= tx_own_q ? tx_bit_w : 1'b1;
      irq_rx_q    <= ctrl_b_q[B_RX_IE] && global_irq_enable && rxc_w;
      irq_tx_q    <= ctrl_b_q[B_TX_IE] && global_irq_enable && txc_q;
      irq_empty_q <= ctrl_b_q[B_EMPTY_IE] && global_irq_enable && buffer_empty_flag_w;
    end
  end

  assign rdata              = rdata_q;
  assign transmit_pin       = tx_pin_q;
  assign transmit_pin_owned = tx_own_q;
  assign receive_pin_owned  = ctrl_b_q[B_RX_EN];
  assign irq_rx_done        = irq_rx_q;
  assign irq_tx_done        = irq_tx_q;
  assign irq_empty          = irq_empty_q;

  // =====================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_tx_load;
    tx_st_q == TX_IDLE && tx_own_q && txb_valid_q;
  endsequence
  sequence s_tx_start_out;
    tx_st_q == TX_START ##1 !tx_pin_q;
  endsequence

  AST_TX_LOAD_START: assert property (s_tx_load |=> s_tx_start_out)
    else $error("transmit load did not drive start bit");
  AST_TX_WRITE_DROPPED: assert property (wr_d_w && txb_valid_q |=> txb_q == $past(txb_q))
    else $error("write to full transmit buffer changed it");
  AST_RXC_READ: assert property (rd && sel_a_w |=> rdata[7] == $past(rx_cnt_q != 2'h0))
    else $error("receive complete bit wrong on read");
  AST_EMPTY_AFTER_RESET: assert property ($fell(rst) |-> stat_a_w[A_EMPTY])
    else $error("buffer empty flag low after reset");
  AST_FLUSH_ON_DISABLE: assert property (!receiver_enable_w |=> rx_cnt_q == 2'h0 && !dor_q)
    else $error("receive fifo not flushed while disabled");
  AST_TX_DISABLE_DEFER: assert property (tx_own_q && tx_st_q != TX_IDLE |=> tx_own_q)
    else $error("transmitter released pin mid frame");
  AST_IRQ_RX_CAUSE: assert property (irq_rx_done |-> $past(rxc_w && global_irq_enable))
    else $error("receive interrupt without cause");
  AST_RX_UPPER_ZERO: assert property (rxc_w |-> (head_w[8:0] & ~mask_w) == 9'h000)
    else $error("receive fifo head has bits above character size");
  AST_TXC_WRITE_CLEAR: assert property (wr_a_w && wdata[A_TX_DONE] && !tx_frame_end_w |=> !txc_q)
    else $error("transmit complete not cleared by write one");

endmodule

// [tb/uart_register_interface_bench.sv]
// self-checking bench for the serial channel register block
`timescale 1ns/1ps
module uart_register_interface_bench;
  import uart_reg_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       global_irq_enable = 1'b0;
  logic       tx_done_irq_ack = 1'b0;
  logic       receive_pin;
  logic       transmit_pin;
  logic       transmit_pin_owned;
  logic       receive_pin_owned;
  logic       irq_rx_done;
  logic       irq_tx_done;
  logic       irq_empty;
  logic [8:0] frame_q;
  int         frames;
  int         errors = 0;
  int         n_tests = 0;
  int         cycles = 0;

  always #25 clk_sys = ~clk_sys;

  uart_register_interface #(.CHANNEL(8'h00), .PRESCALE(16'h0001)) uart_register_interface_inst (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .global_irq_enable(global_irq_enable), .tx_done_irq_ack(tx_done_irq_ack),
    .receive_pin(receive_pin), .transmit_pin(transmit_pin),
    .transmit_pin_owned(transmit_pin_owned), .receive_pin_owned(receive_pin_owned),
    .irq_rx_done(irq_rx_done), .irq_tx_done(irq_tx_done), .irq_empty(irq_empty));

  uart_remote_device #(.BIT_CLKS(16)) uart_remote_device_inst (
    .clk_sys(clk_sys), .line_from_dev(transmit_pin), .line_to_dev(receive_pin),
    .frame_q(frame_q), .frames(frames));

  // =====================================================
  // shared tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 check(name, rdata, exp);
  endtask

  task automatic send(input logic [8:0] bits, input int n, input logic stop);
    @(posedge clk_sys);
    uart_remote_device_inst.send(bits, n, stop);
    repeat (20) @(posedge clk_sys);
  endtask

  // =====================================================
  // scenarios
  task automatic check_reset();
    logic [7:0] ra [5] = '{8'hc0, 8'hc1, 8'hc2, 8'hc6, 8'hc3};
    logic [7:0] rv [5] = '{8'h20, 8'h00, 8'h06, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) rd_chk("reset_value", ra[i], rv[i]);
  endtask

  task automatic check_tx();
    int k;
    k = 0;
    wr_reg(OFF_STATUS_B, 8'h08);
    @(posedge clk_sys);
    wr <= 1'b1; addr <= OFF_DATA_PORT; wdata <= 8'ha5;
    @(posedge clk_sys);
    wdata <= 8'h3c;
    @(posedge clk_sys);
    wr <= 1'b0;
    while (frames < 1 && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (40) @(posedge clk_sys);
    check("tx_owned", {7'h0, transmit_pin_owned}, 8'h01);
    check("tx_data", frame_q[7:0], 8'ha5);
    check("tx_stop", {7'h0, frame_q[8]}, 8'h01);
    rd_chk("tx_done_set", OFF_STATUS_A, 8'h60);
    repeat (200) @(posedge clk_sys);
    check("tx_frames", 8'(frames), 8'h01);
    wr_reg(OFF_STATUS_A, 8'h40);
    rd_chk("tx_done_clr", OFF_STATUS_A, 8'h20);
    wr_reg(OFF_STATUS_B, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1 check("tx_released", {7'h0, transmit_pin_owned}, 8'h00);
  endtask

  task automatic check_rx();
    wr_reg(OFF_STATUS_B, 8'h10);
    repeat (2) @(posedge clk_sys);
    #1 check("rx_owned", {7'h0, receive_pin_owned}, 8'h01);
    send({1'b0, 8'h5a}, 8, 1'b1);
    send({1'b0, 8'h33}, 8, 1'b0);
    rd_chk("rx_head_ok", OFF_STATUS_A, 8'ha0);
    rd_chk("rx_data0", OFF_DATA_PORT, 8'h5a);
    rd_chk("rx_head_fe", OFF_STATUS_A, 8'hb0);
    rd_chk("rx_data1", OFF_DATA_PORT, 8'h33);
    rd_chk("rx_empty", OFF_STATUS_A, 8'h20);
    for (int i = 0; i < 4; i++) send({1'b0, 8'h0f}, 8, 1'b1);
    rd_chk("rx_overrun", OFF_STATUS_A, 8'ha8);
    wr_reg(OFF_STATUS_B, 8'h00);
    rd_chk("rx_flushed", OFF_STATUS_A, 8'h20);
  endtask

  task automatic check_formats();
    wr_reg(OFF_STATUS_B, 8'h10);
    wr_reg(OFF_FRAME_CTRL, 8'h26);
    send({1'b0, 8'h01}, 9, 1'b1);
    rd_chk("parity_err", OFF_STATUS_A, 8'ha4);
    rd_chk("parity_data", OFF_DATA_PORT, 8'h01);
    wr_reg(OFF_FRAME_CTRL, 8'h04);
    send({1'b1, 8'hff}, 7, 1'b1);
    rd_chk("seven_bit", OFF_DATA_PORT, 8'h7f);
    wr_reg(OFF_STATUS_B, 8'h94);
    global_irq_enable <= 1'b1;
    wr_reg(OFF_FRAME_CTRL, 8'h06);
    wr_reg(OFF_STATUS_A, 8'h01);
    send({1'b0, 8'h55}, 9, 1'b1);
    rd_chk("mp_dropped", OFF_STATUS_A, 8'h21);
    send({1'b1, 8'h3c}, 9, 1'b1);
    #1 check("irq_rx_on", {7'h0, irq_rx_done}, 8'h01);
    rd_chk("ninth_bit", OFF_STATUS_B, 8'h96);
    rd_chk("nine_low", OFF_DATA_PORT, 8'h3c);
    repeat (2) @(posedge clk_sys);
    #1 check("irq_rx_off", {7'h0, irq_rx_done}, 8'h00);
    wr_reg(OFF_STATUS_A, 8'h00);
    wr_reg(OFF_STATUS_B, 8'h00);
  endtask

  task automatic check_irq();
    int k;
    k = 0;
    @(posedge clk_sys);
    global_irq_enable <= 1'b1;
    wr_reg(OFF_STATUS_B, 8'h4d);
    wr_reg(OFF_DATA_PORT, 8'h96);
    while (frames < 2 && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (40) @(posedge clk_sys);
    check("tx_ninth", {7'h0, frame_q[8]}, 8'h01);
    check("tx_nine_low", frame_q[7:0], 8'h96);
    #1 check("irq_tx_on", {7'h0, irq_tx_done}, 8'h01);
    @(posedge clk_sys);
    tx_done_irq_ack <= 1'b1;
    @(posedge clk_sys);
    tx_done_irq_ack <= 1'b0;
    rd_chk("tx_ack_clr", OFF_STATUS_A, 8'h20);
    #1 check("irq_tx_off", {7'h0, irq_tx_done}, 8'h00);
    wr_reg(OFF_STATUS_B, 8'h20);
    repeat (2) @(posedge clk_sys);
    #1 check("irq_on", {7'h0, irq_empty}, 8'h01);
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check("irq_off", {7'h0, irq_empty}, 8'h00);
  endtask

  // =====================================================
  // timeout and main sequence
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    check_reset();
    check_tx();
    check_rx();
    check_formats();
    check_irq();
    test_done();
  end
endmodule

// [tb/uart_remote_device.sv]
// far-side serial device model: sends frames and captures transmitted ones
`timescale 1ns/1ps
module uart_remote_device #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic       clk_sys,
  input  wire logic       line_from_dev,
  output logic            line_to_dev,
  output logic      [8:0] frame_q,
  output int              frames
);
  initial begin
    line_to_dev = 1'b1;
    frame_q = '0;
    frames = 0;
  end

  // =====================================================
  // sender: start, data lsb first, one stop bit, then idle high
  task automatic send(input logic [8:0] bits, input int n, input logic stop);
    line_to_dev <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      line_to_dev <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    line_to_dev <= stop;
    repeat (BIT_CLKS) @(posedge clk_sys);
    line_to_dev <= 1'b1;
  endtask

  // =====================================================
  // capture: the nine bits after the start bit (eight data bits and stop, or nine data bits), sampled mid-bit
  always begin
    @(negedge line_from_dev);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    if (line_from_dev === 1'b0) begin
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CLKS) @(posedge clk_sys);
        frame_q[i] <= line_from_dev;
      end
      frames <= frames + 1;
    end
  end
endmodule
